// ### hw/buck_code_decoder.sv
// maps a 6-bit voltage code and a range selector to an output voltage
// assumes combinational use; the caller registers the result
`timescale 1ns/10ps
module buck_code_decoder
(
	input  wire logic [1:0]  range_sel,
	input  wire logic [5:0]  code,
	output logic      [15:0] voltage
);

	function automatic logic [15:0] linear(input logic [15:0] base, input logic [15:0] step, input logic [5:0] c);
		linear = 16'(base + 16'(step * {10'h0, c}));
	endfunction

	always_comb
	begin
		case (buck_limit_pkg::range_e'(range_sel))
			buck_limit_pkg::RANGE_FINE_LOW:
				voltage = linear(buck_limit_pkg::VOLT_BASE_LOW, buck_limit_pkg::VOLT_STEP_FINE, code);
			buck_limit_pkg::RANGE_FINE_HIGH:
				voltage = linear(buck_limit_pkg::VOLT_BASE_HIGH, buck_limit_pkg::VOLT_STEP_FINE, code);
			buck_limit_pkg::RANGE_MID:
				voltage = linear(buck_limit_pkg::VOLT_BASE_LOW, buck_limit_pkg::VOLT_STEP_MID, code);
			buck_limit_pkg::RANGE_WIDE:
			begin
				// top code jumps to the end of the span instead of one step
				if (code == buck_limit_pkg::CODE_TOP)
					voltage = buck_limit_pkg::VOLT_WIDE_TOP;
				else
					voltage = linear(buck_limit_pkg::VOLT_BASE_LOW, buck_limit_pkg::VOLT_STEP_WIDE, code);
			end
			default:
				voltage = buck_limit_pkg::VOLT_BASE_LOW;
		endcase
	end

endmodule

// ### hw/buck_voltage_limit_range.sv
// voltage limit register of the fourth buck converter, with ceiling clamp and decode
// assumes register port, setting registers and default store all run on clock
//
// How it works
// - range in bits 7-6, ceiling 5-0
// - power-on reset reloads programmed default contents
// - setting codes above ceiling become the ceiling
// - ceiling not 00/3F locks both fields
// - range 00: 0.5 V, 12.5 mV steps
// - range 01: 0.7 V, 12.5 mV steps
// - range 10: 0.5 V, 25 mV steps
// - range 11: 0.5 V to 3.8 V, 50 mV
// - range 00 spans 0.5000 to 1.2875 V
// - range 01 starts 0.7000, code 32 1.1000
// - setting codes in bits 5-0 use range
`timescale 1ns/10ps
module buck_voltage_limit_range
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_address,
	input  wire logic [7:0]  reg_write_data,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_read_data,
	input  wire logic [1:0]  default_range,
	input  wire logic [5:0]  default_ceiling,
	input  wire logic        default_reload,
	input  wire logic [5:0]  operating_code,
	input  wire logic [5:0]  scaled_code,
	output logic      [5:0]  operating_clamped,
	output logic      [5:0]  scaled_clamped,
	output logic      [15:0] operating_voltage,
	output logic      [15:0] scaled_voltage,
	output logic      [1:0]  limit_range,
	output logic      [5:0]  limit_ceiling,
	output logic             limit_locked
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic locks(input logic [5:0] ceiling);
		locks = (ceiling != buck_limit_pkg::CEILING_OPEN) && (ceiling != buck_limit_pkg::CEILING_ZERO);
	endfunction

	function automatic logic [5:0] clamp(input logic [5:0] code, input logic [5:0] ceiling);
		clamp = (code > ceiling) ? ceiling : code;
	endfunction

	logic        load_pending;
	logic        limit_write;
	logic        take_default;
	logic [1:0]  next_range;
	logic [5:0]  next_ceiling;
	logic [15:0] operating_decoded;
	logic [15:0] scaled_decoded;

	// ----------------------------------------
	// limit register
	// ----------------------------------------
	assign limit_write  = reg_write && (reg_address == buck_limit_pkg::LIMIT_OFFSET);
	assign take_default = load_pending || default_reload;

	always_comb
	begin
		next_range   = limit_range;
		next_ceiling = limit_ceiling;
		if (take_default)
		begin
			next_range   = default_range;
			next_ceiling = default_ceiling;
		end
		else if (limit_write && !limit_locked)
		begin
			next_range   = reg_write_data[buck_limit_pkg::RANGE_MSB:buck_limit_pkg::RANGE_LSB];
			next_ceiling = reg_write_data[buck_limit_pkg::CEILING_MSB:buck_limit_pkg::CEILING_LSB];
		end
	end

	// defaults are sampled after release, never under the asynchronous reset
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			load_pending <= 1'b1;
		else
			load_pending <= 1'b0;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			limit_range   <= buck_limit_pkg::RESET_RANGE;
			limit_ceiling <= buck_limit_pkg::RESET_CEILING;
			limit_locked  <= 1'b0;
		end
		else
		begin
			limit_range   <= next_range;
			limit_ceiling <= next_ceiling;
			limit_locked  <= locks(next_ceiling);
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			reg_read_data <= buck_limit_pkg::UNMAPPED_READ;
		else if (reg_read)
		begin
			if (reg_address == buck_limit_pkg::LIMIT_OFFSET)
				reg_read_data <= {limit_range, limit_ceiling};
			else
				reg_read_data <= buck_limit_pkg::UNMAPPED_READ;
		end
	end

	// ----------------------------------------
	// clamp and decode of setting codes
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			operating_clamped <= buck_limit_pkg::CEILING_ZERO;
			scaled_clamped    <= buck_limit_pkg::CEILING_ZERO;
		end
		else
		begin
			operating_clamped <= clamp(operating_code, limit_ceiling);
			scaled_clamped    <= clamp(scaled_code, limit_ceiling);
		end
	end

	buck_code_decoder u_operating_decoder
	(
		.range_sel (limit_range),
		.code      (operating_clamped),
		.voltage   (operating_decoded)
	);

	buck_code_decoder u_scaled_decoder
	(
		.range_sel (limit_range),
		.code      (scaled_clamped),
		.voltage   (scaled_decoded)
	);

	// decode is registered so the converter sees a glitch-free word
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			operating_voltage <= buck_limit_pkg::VOLT_BASE_LOW;
			scaled_voltage    <= buck_limit_pkg::VOLT_BASE_LOW;
		end
		else
		begin
			operating_voltage <= operating_decoded;
			scaled_voltage    <= scaled_decoded;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_locked_write_ignored;
		@(posedge clock) disable iff (!reset_n)
		(limit_write && limit_locked && !take_default) |=> $stable(limit_range) && $stable(limit_ceiling);
	endproperty
	a_locked_write_ignored: assert property (p_locked_write_ignored) else $error("locked limit changed on write");

	property p_open_write_stored;
		@(posedge clock) disable iff (!reset_n)
		(limit_write && !limit_locked && !take_default) |=> ({limit_range, limit_ceiling} == $past(reg_write_data));
	endproperty
	a_open_write_stored: assert property (p_open_write_stored) else $error("open write not stored");

	property p_reload_defaults;
		@(posedge clock) disable iff (!reset_n)
		(take_default && reset_n) |=> (limit_range == $past(default_range)) && (limit_ceiling == $past(default_ceiling));
	endproperty
	a_reload_defaults: assert property (p_reload_defaults) else $error("defaults not loaded");

	property p_lock_follows_ceiling;
		@(posedge clock) disable iff (!reset_n)
		limit_locked == ((limit_ceiling != 6'h3f) && (limit_ceiling != 6'h00));
	endproperty
	a_lock_follows_ceiling: assert property (p_lock_follows_ceiling) else $error("lock flag wrong for ceiling");

	property p_operating_clamp;
		@(posedge clock) disable iff (!reset_n)
		reset_n |=> operating_clamped == (($past(operating_code) > $past(limit_ceiling)) ? $past(limit_ceiling) : $past(operating_code));
	endproperty
	a_operating_clamp: assert property (p_operating_clamp) else $error("operating code not clamped");

	property p_scaled_clamp;
		@(posedge clock) disable iff (!reset_n)
		reset_n |=> (scaled_clamped <= $past(limit_ceiling)) && (scaled_clamped <= $past(scaled_code));
	endproperty
	a_scaled_clamp: assert property (p_scaled_clamp) else $error("scaled code above ceiling");

	property p_fine_low_decode;
		@(posedge clock) disable iff (!reset_n)
		(limit_range == 2'h0 && operating_clamped == 6'h3f) |=> (operating_voltage == 16'h324b);
	endproperty
	a_fine_low_decode: assert property (p_fine_low_decode) else $error("range 00 top code not 1.2875 V");

	property p_fine_high_decode;
		@(posedge clock) disable iff (!reset_n)
		(limit_range == 2'h1 && scaled_clamped == 6'h20) |=> (scaled_voltage == 16'h2af8);
	endproperty
	a_fine_high_decode: assert property (p_fine_high_decode) else $error("range 01 code 32 not 1.1000 V");

	property p_wide_top_decode;
		@(posedge clock) disable iff (!reset_n)
		(limit_range == 2'h3 && operating_clamped == 6'h3f) |=> (operating_voltage == 16'h9470);
	endproperty
	a_wide_top_decode: assert property (p_wide_top_decode) else $error("range 11 top code not 3.8 V");

	property p_mid_decode;
		@(posedge clock) disable iff (!reset_n)
		(limit_range == 2'h2) |=> (operating_voltage == 16'(16'h1388 + 16'(16'h00fa * {10'h0, $past(operating_clamped)})));
	endproperty
	a_mid_decode: assert property (p_mid_decode) else $error("range 10 decode wrong");

endmodule

// ### shared/buck_limit_pkg.sv
// constants for the fourth buck converter's voltage limit register
// assumes one 100 MHz clock domain shared with the register port and the setting registers
package buck_limit_pkg;

	// ----------------------------------------
	// register map and field layout
	// ----------------------------------------
	localparam logic [7:0] LIMIT_OFFSET  = 8'h0f;
	localparam int         RANGE_MSB     = 7;
	localparam int         RANGE_LSB     = 6;
	localparam int         CEILING_MSB   = 5;
	localparam int         CEILING_LSB   = 0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------
	// ceiling values that leave the fields open
	// ----------------------------------------
	localparam logic [5:0] CEILING_OPEN = 6'h3f;
	localparam logic [5:0] CEILING_ZERO = 6'h00;

	// ----------------------------------------
	// values held until the defaults load
	// ----------------------------------------
	localparam logic [1:0] RESET_RANGE   = 2'h0;
	localparam logic [5:0] RESET_CEILING = 6'h3f;

	typedef enum logic [1:0]
	{
		RANGE_FINE_LOW  = 2'h0,
		RANGE_FINE_HIGH = 2'h1,
		RANGE_MID       = 2'h2,
		RANGE_WIDE      = 2'h3
	} range_e;

	// ----------------------------------------
	// output voltage, in units of 100 uV
	// ----------------------------------------
	localparam logic [15:0] VOLT_BASE_LOW  = 16'h1388;
	localparam logic [15:0] VOLT_BASE_HIGH = 16'h1b58;
	localparam logic [15:0] VOLT_STEP_FINE = 16'h007d;
	localparam logic [15:0] VOLT_STEP_MID  = 16'h00fa;
	localparam logic [15:0] VOLT_STEP_WIDE = 16'h01f4;
	localparam logic [15:0] VOLT_WIDE_TOP  = 16'h9470;
	localparam logic [5:0]  CODE_TOP       = 6'h3f;

endpackage

// ### test/buck_voltage_limit_range_tb_top.sv
// self-checking bench for the buck voltage limit register
// assumes host_port_model drives the register port; the bench drives defaults and codes
`timescale 1ns/10ps
module buck_voltage_limit_range_tb_top;
	logic        clock, reset_n, reg_write, reg_read, default_reload, limit_locked;
	logic [7:0]  reg_address, reg_write_data, reg_read_data, rd;
	logic [1:0]  default_range, limit_range;
	logic [5:0]  default_ceiling, operating_code, scaled_code, operating_clamped, scaled_clamped, limit_ceiling;
	logic [15:0] operating_voltage, scaled_voltage;
	logic [5:0]  codes [4] = '{6'h00, 6'h01, 6'h20, 6'h3f};
	int          errors, total_checks;

	buck_voltage_limit_range buck_voltage_limit_range_i (.clock, .reset_n, .reg_address, .reg_write_data,
		.reg_write, .reg_read, .reg_read_data, .default_range, .default_ceiling, .default_reload,
		.operating_code, .scaled_code, .operating_clamped, .scaled_clamped, .operating_voltage,
		.scaled_voltage, .limit_range, .limit_ceiling, .limit_locked);
	host_port_model host_port_model_i (.clock, .reg_address, .reg_write_data, .reg_write, .reg_read,
		.reg_read_data);

	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// top code of the wide range breaks the even spacing
	function automatic logic [15:0] volts(input logic [1:0] r, input logic [5:0] c);
		case (r)
			2'h0: return 16'h1388 + 16'h007d * c;
			2'h1: return 16'h1b58 + 16'h007d * c;
			2'h2: return 16'h1388 + 16'h00fa * c;
			default: return (c == 6'h3f) ? 16'h9470 : 16'h1388 + 16'h01f4 * c;
		endcase
	endfunction

	task automatic settle;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic reload(input logic [1:0] r, input logic [5:0] c);
		@(posedge clock);
		default_range <= r;
		default_ceiling <= c;
		default_reload <= 1'b1;
		@(posedge clock);
		default_reload <= 1'b0;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// far above the roughly 120 cycles the sequence needs
	initial
	begin
		#20000;
		errors++;
		end_sim;
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		reset_n = 1'b0;
		default_range = 2'h0;
		default_ceiling = 6'h3f;
		default_reload = 1'b0;
		operating_code = 6'h00;
		scaled_code = 6'h00;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		host_port_model_i.read_reg(8'h0f, rd);
		check(16'(rd), 16'h003f);
		check(16'(limit_locked), 16'h0000);
		host_port_model_i.read_reg(8'h0e, rd);
		check(16'(rd), 16'(buck_limit_pkg::UNMAPPED_READ));
		for (int r = 0; r < 4; r++)
		begin
			host_port_model_i.write_reg(8'h0f, {r[1:0], 6'h3f});
			host_port_model_i.read_reg(8'h0f, rd);
			check(16'(rd), 16'({r[1:0], 6'h3f}));
			for (int k = 0; k < 4; k++)
			begin
				@(posedge clock);
				operating_code <= codes[k];
				scaled_code <= codes[3 - k];
				settle;
				check(operating_voltage, volts(r[1:0], codes[k]));
				check(scaled_voltage, volts(r[1:0], codes[3 - k]));
			end
		end
		// zero ceiling leaves the fields open
		host_port_model_i.write_reg(8'h0f, 8'h40);
		#1;
		check(16'(limit_locked), 16'h0000);
		host_port_model_i.write_reg(8'h0f, 8'h8a);
		@(posedge clock);
		operating_code <= 6'h09;
		scaled_code <= 6'h0b;
		settle;
		check(16'(operating_clamped), 16'h0009);
		check(16'(scaled_clamped), 16'h000a);
		check(scaled_voltage, volts(2'h2, 6'h0a));
		check(16'(limit_locked), 16'h0001);
		check(16'({limit_range, limit_ceiling}), 16'h008a);
		host_port_model_i.write_reg(8'h0f, 8'h3f);
		host_port_model_i.read_reg(8'h0f, rd);
		check(16'(rd), 16'h008a);
		reload(2'h1, 6'h10);
		host_port_model_i.read_reg(8'h0f, rd);
		check(16'(rd), 16'h0050);
		check(16'({limit_range, limit_ceiling}), 16'h0050);
		check(16'(limit_locked), 16'h0001);
		reload(2'h3, 6'h3f);
		host_port_model_i.write_reg(8'h0f, 8'h00);
		host_port_model_i.read_reg(8'h0f, rd);
		check(16'(rd), 16'h0000);
		// second reset in mid-run picks up the new defaults
		@(posedge clock);
		reset_n <= 1'b0;
		default_range <= 2'h2;
		default_ceiling <= 6'h21;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		host_port_model_i.read_reg(8'h0f, rd);
		check(16'(rd), 16'h00a1);
		check(16'({limit_range, limit_ceiling}), 16'h00a1);
		check(16'(limit_locked), 16'h0001);
		end_sim;
	end
endmodule

// ### test/host_port_model.sv
// host side of the limit register port: strobed writes and reads
// assumes the block samples strobes and address on the rising edge of clock
`timescale 1ns/10ps
module host_port_model
(
	input  wire logic       clock,
	output logic      [7:0] reg_address,
	output logic      [7:0] reg_write_data,
	output logic            reg_write,
	output logic            reg_read,
	input  wire logic [7:0] reg_read_data
);
	initial
	begin
		reg_address = 8'h00;
		reg_write_data = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// fields held through the sampling edge, then the data line scrambled
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		reg_address <= addr;
		reg_write_data <= data;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_write_data <= ~data;
	endtask

	// data lands on the same edge that takes the strobe and is read 1 ns later
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock);
		reg_address <= addr;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		data = reg_read_data;
	endtask
endmodule
